//--- hdl/chamber_safety_interlock.v
/*
  Chamber safety interlock: latched trip alarms, boiler fill delay,
  reservoir notification and defrost cascade cooling control, with a
  small register port and a level interrupt.
  Assumes field inputs may be asynchronous and one 200 MHz core clock.
*/
`timescale 1ns/100ps
`include "interlock_defines.vh"


module chamber_safety_interlock #(
  parameter [`FILL_CNT_WIDTH-1:0] FILL_CYCLES =
    `FILL_DELAY_MIN * `SEC_PER_MIN * 40'd`CLK_HZ
) (
  input wire core_clk,
  input wire resetn,
  input wire sys1_oil_pressure_ok,
  input wire sys1_discharge_temp_ok,
  input wire sys1_comp_protect_ok,
  input wire sys2_hilo_pressure_ok,
  input wire sys2_oil_pressure_ok,
  input wire sys2_discharge_temp_ok,
  input wire sys2_comp_protect_ok,
  input wire boiler_overtemp_ok,
  input wire boiler_level_ok,
  input wire reservoir_level_ok,
  input wire defrost_pressure_in,
  input wire alarm_ack,
  input wire sys1_cool_demand,
  input wire cascade_cool_demand,
  input wire pumpdown_request,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire chamber_shutdown,
  output wire alarm_active,
  output wire [`NUM_ALARMS-1:0] alarm_latched,
  output reg sys1_compressor_out,
  output reg cascade_cool_solenoid_out,
  output wire irq
);

  // Synchroniser stages
  reg [`NUM_INPUTS-1:0] in_meta_reg;
  reg [`NUM_INPUTS-1:0] in_sync_reg;
  wire [`NUM_INPUTS-1:0] field_raw;

  // Software state
  reg [`CTRL_WIDTH-1:0] ctrl_reg;
  reg [`NUM_ALARMS-1:0] irq_status_reg;
  reg [`NUM_ALARMS-1:0] irq_status_next;
  reg [`NUM_ALARMS-1:0] irq_mask_reg;

  // Boiler fill timing
  reg humidity_prev_reg;
  reg [`FILL_CNT_WIDTH-1:0] fill_cnt_reg;
  reg fill_expired_reg;
  reg level_reached_reg;
  wire humidity_on;
  wire large_defrost;
  wire boiler_armed;

  // Alarm latches
  wire [`NUM_ALARMS-1:0] tripped;
  wire [`NUM_ALARMS-1:0] set_events;
  wire ack_pulse;
  reg ack_wr_reg;

  function reg_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  assign field_raw = {defrost_pressure_in, reservoir_level_ok, boiler_level_ok,
    boiler_overtemp_ok, sys2_comp_protect_ok, sys2_discharge_temp_ok,
    sys2_oil_pressure_ok, sys2_hilo_pressure_ok, sys1_comp_protect_ok,
    sys1_discharge_temp_ok, sys1_oil_pressure_ok};

  // Two-stage input synchroniser
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      in_meta_reg <= `INPUTS_RESET;
      in_sync_reg <= `INPUTS_RESET;
    end
    else
    begin
      in_meta_reg <= field_raw;
      in_sync_reg <= in_meta_reg;
    end
  end

  // Control register and acknowledge strobe
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl_reg <= `CTRL_RESET;
      ack_wr_reg <= 1'b0;
    end
    else
    begin
      ack_wr_reg <= reg_wr & reg_hit(reg_addr, `REG_CTRL) & reg_wdata[`CTRL_ACK_BIT];
      if (reg_wr && reg_hit(reg_addr, `REG_CTRL))
      begin
        ctrl_reg[`CTRL_HUMIDITY_BIT] <= reg_wdata[`CTRL_HUMIDITY_BIT];
        ctrl_reg[`CTRL_LARGE_DEF_BIT] <= reg_wdata[`CTRL_LARGE_DEF_BIT];
      end
      ctrl_reg[`CTRL_ACK_BIT] <= 1'b0;
    end
  end

  // Acknowledge from pin or register, one cycle each
  assign ack_pulse = alarm_ack | ack_wr_reg;
  assign humidity_on = ctrl_reg[`CTRL_HUMIDITY_BIT];
  assign large_defrost = ctrl_reg[`CTRL_LARGE_DEF_BIT];

  // Boiler fill delay after humidity turns on
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      humidity_prev_reg <= 1'b0;
      fill_cnt_reg <= {`FILL_CNT_WIDTH{1'b0}};
      fill_expired_reg <= 1'b0;
      level_reached_reg <= 1'b0;
    end
    else
    begin
      humidity_prev_reg <= humidity_on;
      if (!humidity_on)
      begin
        fill_cnt_reg <= {`FILL_CNT_WIDTH{1'b0}};
        fill_expired_reg <= 1'b0;
        level_reached_reg <= 1'b0;
      end
      else if (!humidity_prev_reg)
      begin
        fill_cnt_reg <= FILL_CYCLES;
        fill_expired_reg <= 1'b0;
        level_reached_reg <= 1'b0;
      end
      else
      begin
        if (fill_cnt_reg > 1)
          fill_cnt_reg <= fill_cnt_reg - 1'b1;
        else if (fill_cnt_reg == 1)
        begin
          fill_cnt_reg <= {`FILL_CNT_WIDTH{1'b0}};
          fill_expired_reg <= 1'b1;
        end
        if (in_sync_reg[`AL_BOILER_LEVEL])
          level_reached_reg <= 1'b1;
      end
    end
  end

  // Level alarm armed once filled or fill time has run out
  assign boiler_armed = humidity_on & humidity_prev_reg &
    (level_reached_reg | fill_expired_reg);

  // One latch per alarm input
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_ALARMS; gi = gi + 1)
    begin : g_trip
      trip_latch #(
        .NEED_RESTORE((gi == `AL_BOILER_LEVEL || gi == `AL_RESERVOIR) ? 0 : 1)
      ) u_trip (
        .core_clk(core_clk),
        .resetn(resetn),
        .ok_in(in_sync_reg[gi]),
        .arm((gi == `AL_BOILER_LEVEL) ? boiler_armed : 1'b1),
        .ack(ack_pulse),
        .tripped(tripped[gi]),
        .set_event(set_events[gi])
      );
    end
  endgenerate

  assign alarm_latched = tripped;
  // Shutdown from shutdown-class alarms only, reservoir excluded
  assign chamber_shutdown = |(tripped & `SHUTDOWN_MASK);
  assign alarm_active = |tripped;

  // Defrost cascade cooling control
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sys1_compressor_out <= 1'b0;
      cascade_cool_solenoid_out <= 1'b0;
    end
    else
    begin
      cascade_cool_solenoid_out <= cascade_cool_demand &
        (in_sync_reg[`IN_DEFROST] | ~large_defrost);
      sys1_compressor_out <= pumpdown_request |
        (sys1_cool_demand & ~chamber_shutdown &
        (in_sync_reg[`IN_DEFROST] | large_defrost));
    end
  end

  // Sticky interrupt status, set wins over clear-on-read
  always @*
  begin
    irq_status_next = irq_status_reg;
    if (reg_rd && reg_hit(reg_addr, `REG_IRQ_STATUS))
      irq_status_next = `ALARM_RESET;
    irq_status_next = irq_status_next | set_events;
  end

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      irq_status_reg <= `ALARM_RESET;
      irq_mask_reg <= `MASK_RESET;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (reg_wr && reg_hit(reg_addr, `REG_IRQ_MASK))
        irq_mask_reg <= reg_wdata[`NUM_ALARMS-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge core_clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_CTRL:
          reg_rdata <= {29'h0000_0000, ctrl_reg};
        `REG_ALARM:
          reg_rdata <= {22'h00_0000, tripped};
        `REG_INPUTS:
          reg_rdata <= {21'h00_0000, in_sync_reg};
        `REG_IRQ_STATUS:
          reg_rdata <= {22'h00_0000, irq_status_reg};
        `REG_IRQ_MASK:
          reg_rdata <= {22'h00_0000, irq_mask_reg};
        `REG_OUTPUTS:
          reg_rdata <= {25'h000_0000, fill_expired_reg, level_reached_reg, irq,
            alarm_active, chamber_shutdown, cascade_cool_solenoid_out, sys1_compressor_out};
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // chamber_safety_interlock

//--- pkg/interlock_defines.vh
/*
  Shared constants for the chamber safety interlock: register offsets,
  control bit positions, alarm indices, reset values and timing.
  Assumes a 200 MHz core clock and a byte-addressed register port.
*/
`ifndef INTERLOCK_DEFINES_VH
`define INTERLOCK_DEFINES_VH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_ALARM       8'h04
`define REG_INPUTS      8'h08
`define REG_IRQ_STATUS  8'h0C
`define REG_IRQ_MASK    8'h10
`define REG_OUTPUTS     8'h14

// Control register bits
`define CTRL_HUMIDITY_BIT  0
`define CTRL_LARGE_DEF_BIT 1
`define CTRL_ACK_BIT       2
`define CTRL_RESET         3'h0
`define CTRL_WIDTH         3

// Alarm indices
`define AL_SYS1_OIL      0
`define AL_SYS1_DISCH    1
`define AL_SYS1_COMP     2
`define AL_SYS2_HILO     3
`define AL_SYS2_OIL      4
`define AL_SYS2_DISCH    5
`define AL_SYS2_COMP     6
`define AL_BOILER_TEMP   7
`define AL_BOILER_LEVEL  8
`define AL_RESERVOIR     9
`define IN_DEFROST       10
`define NUM_ALARMS       10
`define NUM_INPUTS       11

// Alarms that force chamber shutdown
`define SHUTDOWN_MASK    10'h1FF
`define ALARM_RESET      10'h000
`define MASK_RESET       10'h000
`define INPUTS_RESET     11'h7FF

// Boiler fill delay
`define FILL_DELAY_MIN   30
`define SEC_PER_MIN      60
`define CLK_HZ           200000000
`define FILL_CNT_WIDTH   40

`endif

//--- hdl/trip_latch.v
/*
  One latched safety alarm.
  Assumes ok_in is already synchronised and ack is a one-cycle pulse.
*/
`timescale 1ns/100ps
`include "interlock_defines.vh"

module trip_latch #(
  parameter NEED_RESTORE = 1
) (
  input wire core_clk,
  input wire resetn,
  input wire ok_in,
  input wire arm,
  input wire ack,
  output wire tripped,
  output wire set_event
);

  reg latched_reg;
  wire set_cond;
  wire clear_cond;

  // Trip on low level while evaluation is armed
  assign set_cond = arm & ~ok_in;
  // Release by acknowledge, with input restored where required
  assign clear_cond = ack & (ok_in | (NEED_RESTORE == 0));
  assign set_event = set_cond & ~latched_reg;
  assign tripped = latched_reg;

  always @(posedge core_clk)
  begin
    if (!resetn)
      latched_reg <= 1'b0;
    else if (set_cond)
      latched_reg <= 1'b1;
    else if (clear_cond)
      latched_reg <= 1'b0;
  end

endmodule // trip_latch

//--- verification/field_switches.sv
/*
  Field switch model: safety contacts and defrost pressure switch.
  Assumes the bench sets the wanted contact levels.
*/
`timescale 1ns/100ps
module field_switches (
  input wire core_clk,
  input wire [10:0] want,
  output reg [10:0] pins
);
  // All contacts healthy, reservoir jumpered high
  initial pins = 11'h7FF;
  // Contacts open low on a fault
  always @(posedge core_clk)
    pins <= want;
endmodule // field_switches

//--- verification/chamber_safety_interlock_assertions.sv
/*
  Port checker for the chamber safety interlock.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
module chamber_safety_interlock_assertions #(
  parameter [39:0] FILL_CYCLES = 40'h32
) (
  input wire core_clk,
  input wire resetn,
  input wire sys1_oil_pressure_ok,
  input wire sys1_discharge_temp_ok,
  input wire sys1_comp_protect_ok,
  input wire sys2_hilo_pressure_ok,
  input wire sys2_oil_pressure_ok,
  input wire sys2_discharge_temp_ok,
  input wire sys2_comp_protect_ok,
  input wire boiler_overtemp_ok,
  input wire boiler_level_ok,
  input wire reservoir_level_ok,
  input wire defrost_pressure_in,
  input wire alarm_ack,
  input wire sys1_cool_demand,
  input wire cascade_cool_demand,
  input wire pumpdown_request,
  input wire reg_wr,
  input wire chamber_shutdown,
  input wire alarm_active,
  input wire [9:0] alarm_latched,
  input wire sys1_compressor_out,
  input wire cascade_cool_solenoid_out
);
  wire [9:0] ok = {reservoir_level_ok, boiler_level_ok, boiler_overtemp_ok, sys2_comp_protect_ok,
    sys2_discharge_temp_ok, sys2_oil_pressure_ok, sys2_hilo_pressure_ok, sys1_comp_protect_ok,
    sys1_discharge_temp_ok, sys1_oil_pressure_ok};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  genvar i;
  for (i = 0; i < 10; i = i + 1)
  begin : g_al
    if (i != 8)
    begin : g_trip
      property p_trip_set;
        $fell(ok[i]) && !alarm_latched[i] |-> ##1 !alarm_latched[i] ##1 !alarm_latched[i] ##1 alarm_latched[i];
      endproperty
      a_trip_set: assert property (p_trip_set) else $error("Trip not latched on time");
      property p_hold_low;
        alarm_latched[i] && !ok[i] && !$past(ok[i]) && !$past(ok[i], 2) |=> alarm_latched[i];
      endproperty
      a_hold_low: assert property (p_hold_low) else $error("Alarm dropped with input low");
    end
    property p_clear_ack;
      $fell(alarm_latched[i]) |-> $past(alarm_ack) || $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    a_clear_ack: assert property (p_clear_ack) else $error("Alarm cleared without ack");
  end
  property p_shutdown_or;
    chamber_shutdown == (|alarm_latched[8:0]);
  endproperty
  a_shutdown_or: assert property (p_shutdown_or) else $error("Shutdown not OR of alarms");
  property p_active;
    alarm_active == (|alarm_latched);
  endproperty
  a_active: assert property (p_active) else $error("Alarm active wrong");
  property p_cool_on;
    (defrost_pressure_in && cascade_cool_demand && sys1_cool_demand && !chamber_shutdown)[*4]
      |-> cascade_cool_solenoid_out && sys1_compressor_out;
  endproperty
  a_cool_on: assert property (p_cool_on) else $error("Cascade cooling not on");
  property p_cool_off;
    (!defrost_pressure_in && !pumpdown_request)[*4] |-> !(cascade_cool_solenoid_out && sys1_compressor_out);
  endproperty
  a_cool_off: assert property (p_cool_off) else $error("Cascade cooling not stopped");
  property p_pumpdown;
    pumpdown_request[*2] |-> sys1_compressor_out;
  endproperty
  a_pumpdown: assert property (p_pumpdown) else $error("Pumpdown left compressor off");
endmodule // chamber_safety_interlock_assertions

bind chamber_safety_interlock chamber_safety_interlock_assertions #(.FILL_CYCLES(FILL_CYCLES)) chk_inst (
  .core_clk(core_clk), .resetn(resetn), .sys1_oil_pressure_ok(sys1_oil_pressure_ok),
  .sys1_discharge_temp_ok(sys1_discharge_temp_ok), .sys1_comp_protect_ok(sys1_comp_protect_ok),
  .sys2_hilo_pressure_ok(sys2_hilo_pressure_ok), .sys2_oil_pressure_ok(sys2_oil_pressure_ok),
  .sys2_discharge_temp_ok(sys2_discharge_temp_ok), .sys2_comp_protect_ok(sys2_comp_protect_ok),
  .boiler_overtemp_ok(boiler_overtemp_ok), .boiler_level_ok(boiler_level_ok),
  .reservoir_level_ok(reservoir_level_ok), .defrost_pressure_in(defrost_pressure_in), .alarm_ack(alarm_ack),
  .sys1_cool_demand(sys1_cool_demand), .cascade_cool_demand(cascade_cool_demand),
  .pumpdown_request(pumpdown_request), .reg_wr(reg_wr), .chamber_shutdown(chamber_shutdown),
  .alarm_active(alarm_active), .alarm_latched(alarm_latched), .sys1_compressor_out(sys1_compressor_out),
  .cascade_cool_solenoid_out(cascade_cool_solenoid_out));

//--- verification/chamber_safety_interlock_test.sv
/*
  Self-checking bench for the chamber safety interlock.
  Assumes a 50-cycle boiler fill time and the field switch model.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module chamber_safety_interlock_test;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg [10:0] want = 11'h7FF;
  reg alarm_ack = 1'b0;
  reg sys1_cool_demand = 1'b0;
  reg cascade_cool_demand = 1'b0;
  reg pumpdown_request = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [31:0] d;
  wire [10:0] p;
  wire [31:0] reg_rdata;
  wire [9:0] alarm_latched;
  wire chamber_shutdown, alarm_active, sys1_compressor_out, cascade_cool_solenoid_out, irq;
  int bad_count = 0;
  int num_checks = 0;
  int i;
  always #2.5 core_clk = ~core_clk;
  field_switches field_switches_inst (.core_clk(core_clk), .want(want), .pins(p));
  chamber_safety_interlock #(.FILL_CYCLES(40'h32)) chamber_safety_interlock_inst (.core_clk(core_clk),
    .resetn(resetn), .sys1_oil_pressure_ok(p[0]), .sys1_discharge_temp_ok(p[1]), .sys1_comp_protect_ok(p[2]),
    .sys2_hilo_pressure_ok(p[3]), .sys2_oil_pressure_ok(p[4]), .sys2_discharge_temp_ok(p[5]),
    .sys2_comp_protect_ok(p[6]), .boiler_overtemp_ok(p[7]), .boiler_level_ok(p[8]), .reservoir_level_ok(p[9]),
    .defrost_pressure_in(p[10]), .alarm_ack(alarm_ack), .sys1_cool_demand(sys1_cool_demand),
    .cascade_cool_demand(cascade_cool_demand), .pumpdown_request(pumpdown_request), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chamber_shutdown(chamber_shutdown), .alarm_active(alarm_active), .alarm_latched(alarm_latched),
    .sys1_compressor_out(sys1_compressor_out), .cascade_cool_solenoid_out(cascade_cool_solenoid_out), .irq(irq));
  task cy(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task ack;
    @(posedge core_clk);
    alarm_ack <= 1'b1;
    @(posedge core_clk);
    alarm_ack <= 1'b0;
  endtask
  task t_reservoir;
    want[9] <= 1'b0;
    cy(8);
    `CHK("res latch", 10'h200, alarm_latched)
    `CHK("res shutdown", 1'b0, chamber_shutdown)
    `CHK("masked irq", 1'b0, irq)
    wr(8'h10, 32'h200);
    cy(1);
    `CHK("irq", 1'b1, irq)
    rd(8'h0C);
    `CHK("status", 32'h200, d)
    cy(1);
    `CHK("irq clear", 1'b0, irq)
    rd(8'hFC);
    `CHK("unmapped", 32'h0, d)
    rd(8'h04);
    `CHK("alarm reg", 32'h200, d)
    want[9] <= 1'b1;
    cy(8);
    `CHK("res held", 10'h200, alarm_latched)
    wr(8'h00, 32'h4);
    cy(2);
    `CHK("res clear", 10'h000, alarm_latched)
  endtask
  task t_trips;
    for (i = 0; i < 8; i++)
    begin
      want[i] <= 1'b0;
      cy(8);
      `CHK("trip", 10'h001 << i, alarm_latched)
      `CHK("shutdown", 1'b1, chamber_shutdown)
      ack;
      cy(4);
      `CHK("ack low", 10'h001 << i, alarm_latched)
      want[i] <= 1'b1;
      cy(8);
      `CHK("no ack", 10'h001 << i, alarm_latched)
      ack;
      cy(2);
      `CHK("cleared", 1'b0, chamber_shutdown)
    end
  endtask
  task t_boiler;
    want[8] <= 1'b0;
    wr(8'h00, 32'h1);
    cy(40);
    `CHK("fill", 1'b0, alarm_latched[8])
    cy(20);
    `CHK("fill end", 1'b1, alarm_latched[8])
    `CHK("boiler stop", 1'b1, chamber_shutdown)
    want[8] <= 1'b1;
    cy(8);
    ack;
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    cy(8);
    `CHK("boiler clear", 1'b0, alarm_latched[8])
    want[8] <= 1'b0;
    cy(8);
    `CHK("level loss", 1'b1, alarm_latched[8])
    want[8] <= 1'b1;
    cy(8);
    ack;
    wr(8'h00, 32'h0);
  endtask
  task t_defrost;
    @(posedge core_clk);
    sys1_cool_demand <= 1'b1;
    cascade_cool_demand <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      wr(8'h00, {30'h0, i[1], 1'b0});
      want[10] <= i[0];
      cy(8);
      `CHK("solenoid", i[0] | ~i[1], cascade_cool_solenoid_out)
      `CHK("compressor", i[0] | i[1], sys1_compressor_out)
    end
    @(posedge core_clk);
    sys1_cool_demand <= 1'b0;
    pumpdown_request <= 1'b1;
    cy(4);
    `CHK("pumpdown", 1'b1, sys1_compressor_out)
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    bad_count++;
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    cy(4);
    t_reservoir;
    t_trips;
    t_boiler;
    t_defrost;
    end_of_test;
  end
endmodule // chamber_safety_interlock_test
